/* File: rtl/hrc_pkg.sv */
// shared constants, register map and types of the halt release controller
package hrc_pkg;

	// ==========================================================
	// register map (byte addresses on the apb bus)
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_FLAGS  = 8'h04;
	localparam logic [7:0] OFF_IRQ    = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;

	// ==========================================================
	// field positions
	localparam int FLG_CARRY  = 0;
	localparam int FLG_KEY    = 1;
	localparam int IRQ_EXT    = 0;
	localparam int IRQ_TMR    = 1;
	localparam int STS_HALTED = 0;
	localparam int STS_INSVC  = 1;
	localparam int STS_GIE    = 2;
	localparam int STS_OP_LSB = 4;
	localparam int STS_KEYLSB = 8;
	localparam int STS_VECLSB = 16;

	// halt operand bits
	localparam int OP_KEY = 0;
	localparam int OP_TMR = 1;
	localparam int OP_IRQ = 3;

	// ==========================================================
	// reset values; reset itself clears the pull-downs, PULLDN_RST loads after it
	localparam logic [5:0] CTRL_RST    = 6'h00;
	localparam logic [3:0] PULLDN_RST  = 4'hf;
	localparam logic [15:0] VEC_RST    = 16'h0000;

	// ==========================================================
	// timing
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int MS_TIME      = 1;
	localparam int CYC_PER_MS   = CLK_FREQ_KHZ * MS_TIME;
	localparam logic [7:0] INTV_MS0 = 8'h01;
	localparam logic [7:0] INTV_MS1 = 8'h05;
	localparam logic [7:0] INTV_MS2 = 8'h64;
	localparam logic [7:0] INTV_MS3 = 8'hfa;

	// interrupt vectors
	localparam logic [15:0] VEC_TMR = 16'h0003;
	localparam logic [15:0] VEC_EXT = 16'h0005;

	// ==========================================================
	// types
	typedef struct packed {
		logic       perm_tmr;
		logic       perm_ext;
		logic [1:0] tick_sel;
		logic [1:0] carry_sel;
	} hrc_ctrl_s;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_HALT = 2'b10
	} hrc_state_e;

endpackage : hrc_pkg

/* File: rtl/hrc_top.sv */
// halt release controller with apb register access
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Contract
// R1: key pins usable as inputs with pull-downs
// R2: operand 0010B selects timer carry release
// R3: release at once when carry flag is set
// R4: carry flag set at 1/5/100/250 ms
// R5: both select bits high give 250 ms
// R6: operand 1000B selects interrupt release
// R7: release when ext or timer irq acknowledged
// R8: ack needs global enable, permit, request
// R9: disabled pending request never acks or releases
// R10: vectors 0003H timer, 0005H external pin
// R11: interrupt return resumes after the halt
// R12: external pin wins over timer when simultaneous
// R13: pending enabled request acked on interrupt return
// R14: halt sees stale flags; pending means ignored
// R15: software puts a nop before halt
// R16: any selected condition releases halt
// R17: cause readable by vector, carry, key flag
// R18: leaving halt keeps carry flag set
// R19: software tests every condition by priority
// R20: operand 0001B releases on any key high
// R21: operand 0000B only reset ends halt
// R22: non-interrupt release resumes after halt
// R23: release is or of operand bits and sources
module hrc_top #(
	parameter int CYC_PER_MS = hrc_pkg::CYC_PER_MS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  key_input_pins,
	input  wire logic        ext_irq_pin,
	input  wire logic        instr_retire,
	input  wire logic        instr_halt,
	input  wire logic [3:0]  halt_operand,
	input  wire logic        global_irq_enable_instr,
	input  wire logic        global_irq_disable_instr,
	input  wire logic        return_from_irq_instr,
	output logic             cpu_halted,
	output logic             cpu_resume,
	output logic             irq_ack,
	output logic      [15:0] irq_vector,
	output logic             halt_ignored,
	output logic      [3:0]  key_pulldown_en
);

	// ==========================================================
	// state
	hrc_pkg::hrc_ctrl_s  ctrl_r;
	hrc_pkg::hrc_state_e st_r;
	hrc_pkg::hrc_state_e st_nxt;
	logic [3:0]  op_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [3:0]  key_s1_r;
	logic [3:0]  key_s2_r;
	logic        ext_s1_r;
	logic        ext_s2_r;
	logic        ext_s3_r;
	logic        carry_r;
	logic        keyflag_r;
	logic [1:0]  irq_req_r;
	logic [1:0]  irq_req_nxt;
	logic [1:0]  irq_snap_r;
	logic        gie_r;
	logic        in_svc_r;
	logic [15:0] vec_r;
	logic        halted_r;
	logic        resume_r;
	logic        ack_r;
	logic        ignored_r;
	logic [3:0]  pulldn_r;
	logic [31:0] pre_cnt_r;
	logic        ms_tick_r;
	logic [1:0]  tick_r;

	// ==========================================================
	// apb decode
	// reads are captured in the setup cycle, so prdata
	// is already settled when pready rises
	wire setup_ph = psel & ~penable;
	wire access   = psel & penable & pready_r;
	wire wr       = access & pwrite;
	wire hit_ctrl = paddr == hrc_pkg::OFF_CTRL;
	wire hit_flg  = paddr == hrc_pkg::OFF_FLAGS;
	wire hit_irq  = paddr == hrc_pkg::OFF_IRQ;
	wire hit_sts  = paddr == hrc_pkg::OFF_STATUS;
	wire hit_any  = hit_ctrl | hit_flg | hit_irq | hit_sts;
	wire wr_ctrl  = wr & hit_ctrl;
	wire wr_flg   = wr & hit_flg;
	wire wr_irq   = wr & hit_irq;

	wire [31:0] rd_ctrl = {26'h0, ctrl_r};
	wire [31:0] rd_flg  = {30'h0, keyflag_r, carry_r};
	wire [31:0] rd_irq  = {30'h0, irq_req_r};
	wire [31:0] rd_sts  = {vec_r, 4'h0, key_s2_r, op_r, 1'b0,
			gie_r, in_svc_r, halted_r};
	wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
			hit_flg ? rd_flg :
			hit_irq ? rd_irq :
			hit_sts ? rd_sts : 32'h0;

	// ==========================================================
	// interrupt acknowledge
	// a request counts only when permitted and globally enabled
	wire [1:0] perm = {ctrl_r.perm_tmr, ctrl_r.perm_ext};
	wire [1:0] pend = perm & irq_req_r; // see R8 see R9
	wire [1:0] stale_pend = perm & irq_snap_r;
	wire svc_busy = in_svc_r & ~return_from_irq_instr;
	wire in_halt  = st_r == hrc_pkg::ST_HALT;
	// running cpu takes interrupts at instruction boundaries only
	wire ack_slot = in_halt ? op_r[hrc_pkg::OP_IRQ] :
			(instr_retire | return_from_irq_instr); // see R13
	wire ack_now  = gie_r & ~svc_busy & (|pend) & ack_slot; // see R8
	// fixed priority, external pin first
	wire ack_ext  = ack_now & pend[hrc_pkg::IRQ_EXT]; // see R12
	wire ack_tmr  = ack_now & ~pend[hrc_pkg::IRQ_EXT];
	wire [15:0] ack_vec = ack_ext ? hrc_pkg::VEC_EXT :
			hrc_pkg::VEC_TMR; // see R10
	wire [1:0] ack_bits = {ack_tmr, ack_ext};

	// ==========================================================
	// release evaluation
	wire key_any = |key_s2_r; // see R20
	wire release_req = (op_r[hrc_pkg::OP_KEY] & key_any) |
			(op_r[hrc_pkg::OP_TMR] & carry_r) | // see R2
			(op_r[hrc_pkg::OP_IRQ] & ack_now); // see R23 see R16 see R6
	// halt is judged on flags one instruction old
	wire halt_block = halt_operand[hrc_pkg::OP_IRQ] & gie_r &
			(|stale_pend); // see R14
	// edge taken behind the synchroniser; the pin idles low,
	// so no false edge follows reset
	wire ext_rise = ext_s2_r & ~ext_s3_r;
	wire [1:0] set_evt = {tick_r[1], ext_rise};

	// ==========================================================
	// halt state machine
	// zero operand never matches, so only reset leaves halt
	// a refused halt stays in run, pulses halt_ignored
	// and still loads op_r
	always_comb begin
		st_nxt = st_r;
		case (st_r)
		hrc_pkg::ST_RUN: begin
			if (instr_halt && !halt_block) begin
				st_nxt = hrc_pkg::ST_HALT;
			end
		end
		hrc_pkg::ST_HALT: begin
			if (release_req) begin
				st_nxt = hrc_pkg::ST_RUN; // see R3 see R7 see R21
			end
		end
		default: begin
			st_nxt = hrc_pkg::ST_RUN;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= hrc_pkg::ST_RUN;
			op_r      <= 4'h0;
			halted_r  <= 1'b0;
			resume_r  <= 1'b0;
			ignored_r <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			halted_r  <= st_nxt == hrc_pkg::ST_HALT;
			// resume points at the instruction after the halt
			resume_r  <= in_halt & release_req; // see R22 see R11
			ignored_r <= (st_r == hrc_pkg::ST_RUN) & instr_halt &
					halt_block;
			if (st_r == hrc_pkg::ST_RUN && instr_halt) begin
				op_r <= halt_operand;
			end
		end
	end

	// ==========================================================
	// interrupt flags
	// hardware set wins over a software clear in the same cycle
	// a write replaces the request, an ack clears it,
	// a new event beats both
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			irq_req_nxt[i] = set_evt[i] |
					(wr_irq ? pwdata[i] :
					(irq_req_r[i] & ~ack_bits[i]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req_r  <= 2'h0;
			irq_snap_r <= 2'h0;
			gie_r      <= 1'b0;
			in_svc_r   <= 1'b0;
			vec_r      <= hrc_pkg::VEC_RST;
			ack_r      <= 1'b0;
		end else begin
			irq_req_r <= irq_req_nxt;
			if (instr_retire) begin
				irq_snap_r <= irq_req_r; // see R14
			end
			if (ack_now) begin
				gie_r <= 1'b0;
			end else if (global_irq_enable_instr) begin
				gie_r <= 1'b1;
			end else if (global_irq_disable_instr) begin
				gie_r <= 1'b0;
			end
			in_svc_r <= ack_now | svc_busy; // see R11
			ack_r    <= ack_now;
			if (ack_now) begin
				vec_r <= ack_vec; // see R17
			end
		end
	end

	// ==========================================================
	// pin synchronisers
	// two flops per key pin, three on the ext pin; the first one never feeds logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_s1_r <= 4'h0;
			key_s2_r <= 4'h0;
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			pulldn_r <= 4'h0;
		end else begin
			key_s1_r <= key_input_pins;
			key_s2_r <= key_s1_r;
			ext_s1_r <= ext_irq_pin;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			pulldn_r <= hrc_pkg::PULLDN_RST; // see R1
		end
	end

	// ==========================================================
	// interval timers: channel 0 carry flag, channel 1 tick irq
	// one shared millisecond enable keeps both channels in
	// step and costs a single wide counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_r <= 32'h0;
			ms_tick_r <= 1'b0;
		end else begin
			ms_tick_r <= pre_cnt_r == 32'(CYC_PER_MS - 1);
			if (pre_cnt_r == 32'(CYC_PER_MS - 1)) begin
				pre_cnt_r <= 32'h0;
			end else begin
				pre_cnt_r <= pre_cnt_r + 32'h1;
			end
		end
	end

	wire [1:0] ch_sel [2];
	assign ch_sel[0] = ctrl_r.carry_sel;
	assign ch_sel[1] = ctrl_r.tick_sel;

	for (genvar g = 0; g < 2; g++) begin : g_tmr
		logic [7:0] ms_cnt_r;
		wire  [7:0] limit = (ch_sel[g] == 2'h0) ? hrc_pkg::INTV_MS0 :
				(ch_sel[g] == 2'h1) ? hrc_pkg::INTV_MS1 :
				(ch_sel[g] == 2'h2) ? hrc_pkg::INTV_MS2 :
				hrc_pkg::INTV_MS3; // see R4 see R5
		// a shorter select mid-count wraps on the next millisecond tick, no lost tick
		wire  wrap = ms_tick_r & ((ms_cnt_r + 8'h1) >= limit);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ms_cnt_r  <= 8'h0;
				tick_r[g] <= 1'b0;
			end else begin
				tick_r[g] <= wrap;
				if (wrap) begin
					ms_cnt_r <= 8'h0;
				end else if (ms_tick_r) begin
					ms_cnt_r <= ms_cnt_r + 8'h1;
				end
			end
		end
	end

	// ==========================================================
	// carry and key flags, cleared only by software write-one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_r   <= 1'b0;
			keyflag_r <= 1'b0;
		end else begin
			// halt exit does not touch carry_r
			carry_r   <= tick_r[0] | (carry_r &
					~(wr_flg & pwdata[hrc_pkg::FLG_CARRY])); // see R18
			keyflag_r <= key_any | (keyflag_r &
					~(wr_flg & pwdata[hrc_pkg::FLG_KEY])); // see R17
		end
	end

	// ==========================================================
	// apb slave: one wait-free access cycle
	// pready is a one-cycle pulse, and a setup straight
	// after an access is accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= hrc_pkg::CTRL_RST;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph & ~hit_any;
			if (setup_ph) begin
				prdata_r <= rd_data;
			end
			if (wr_ctrl) begin
				ctrl_r <= pwdata[5:0];
			end
		end
	end

	// ==========================================================
	// outputs
	// all straight from flops, so no decode glitch reaches a pin
	assign prdata          = prdata_r;
	assign pready          = pready_r;
	assign pslverr         = pslverr_r;
	assign cpu_halted      = halted_r;
	assign cpu_resume      = resume_r;
	assign irq_ack         = ack_r;
	assign irq_vector      = vec_r;
	assign halt_ignored    = ignored_r;
	assign key_pulldown_en = pulldn_r;

endmodule : hrc_top

/* File: bench/hrc_props.sv */
// port assertions of the halt release controller
`timescale 1ns/1ps
module hrc_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        instr_halt,
	input wire logic [3:0]  halt_operand,
	input wire logic [3:0]  key_input_pins,
	input wire logic        cpu_halted,
	input wire logic        cpu_resume,
	input wire logic        irq_ack,
	input wire logic [15:0] irq_vector,
	input wire logic        halt_ignored,
	input wire logic [3:0]  key_pulldown_en
);
	// =====
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_pd; $past(presetn) |-> key_pulldown_en == 4'hf; endproperty
	a_pd: assert property (p_pd) else $error("pull-downs off");
	property p_op0;
		instr_halt && halt_operand == 4'h0 && !cpu_halted |=> cpu_halted [*8];
	endproperty
	a_op0: assert property (p_op0) else $error("empty halt left");
	property p_key;
		cpu_halted && halt_operand[0] && |key_input_pins |-> ##[1:5] cpu_resume;
	endproperty
	a_key: assert property (p_key) else $error("key no release");
	property p_res; cpu_resume |-> !cpu_halted && $past(cpu_halted); endproperty
	a_res: assert property (p_res) else $error("bad resume");
	property p_ign;
		halt_ignored |-> $past(instr_halt) && $past(halt_operand[3]) && !cpu_halted;
	endproperty
	a_ign: assert property (p_ign) else $error("bad ignore");
	property p_ent; $rose(cpu_halted) |-> $past(instr_halt) && !halt_ignored; endproperty
	a_ent: assert property (p_ent) else $error("bad halt entry");
	property p_ack; cpu_halted && halt_operand[3] ##1 irq_ack |-> cpu_resume; endproperty
	a_ack: assert property (p_ack) else $error("ack kept halt");
	property p_vec;
		irq_ack |-> irq_vector == hrc_pkg::VEC_TMR || irq_vector == hrc_pkg::VEC_EXT;
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
endmodule : hrc_props

bind hrc_top hrc_props hrc_props_i (
	.pclk(pclk), .presetn(presetn), .instr_halt(instr_halt),
	.halt_operand(halt_operand), .key_input_pins(key_input_pins),
	.cpu_halted(cpu_halted), .cpu_resume(cpu_resume), .irq_ack(irq_ack),
	.irq_vector(irq_vector), .halt_ignored(halt_ignored),
	.key_pulldown_en(key_pulldown_en));

/* File: bench/hrc_key_model.sv */
// key switches and external interrupt source
`timescale 1ns/1ps
module hrc_key_model (
	input  wire logic       pclk,
	input  wire logic [3:0] press,
	input  wire logic       ext_fire,
	output logic      [3:0] key_input_pins,
	output logic            ext_irq_pin
);
	logic [2:0] ext_cnt_r = 3'h0;
	// open switches leave pins at the pull-down level
	assign key_input_pins = press;
	// stretched so the synchroniser cannot miss it
	always_ff @(posedge pclk) begin
		ext_cnt_r <= ext_fire ? 3'h4 : ext_cnt_r - {2'h0, ext_cnt_r != 3'h0};
	end
	assign ext_irq_pin = ext_cnt_r != 3'h0;
endmodule : hrc_key_model

/* File: bench/hrc_top_tb.sv */
// self-checking bench of the halt release controller
`timescale 1ns/1ps
module hrc_top_tb;
	localparam int CYC = 10;
	localparam logic [7:0] IV [4] = '{hrc_pkg::INTV_MS0, hrc_pkg::INTV_MS1,
		hrc_pkg::INTV_MS2, hrc_pkg::INTV_MS3};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready;
	logic        pslverr;
	logic        rerr;
	logic [3:0]  press = 4'h0;
	logic [3:0]  keys;
	logic [3:0]  op = 4'h0;
	logic [3:0]  pd;
	logic [3:0]  ins = 4'h0; // retire, halt, ei, return_from_irq_instr
	logic        ext_fire = 1'b0;
	logic        ext_pin;
	logic        halted, resume, ack, ignored;
	logic [15:0] vec;
	int          fails = 0;
	int          tests_run = 0;
	time         t0 = 0;

	always #4 pclk = ~pclk;

	hrc_top #(.CYC_PER_MS(CYC)) hrc_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.key_input_pins(keys), .ext_irq_pin(ext_pin), .instr_retire(ins[0]),
		.instr_halt(ins[1]), .halt_operand(op), .global_irq_enable_instr(ins[2]),
		.global_irq_disable_instr(1'b0), .return_from_irq_instr(ins[3]),
		.cpu_halted(halted), .cpu_resume(resume), .irq_ack(ack),
		.irq_vector(vec), .halt_ignored(ignored), .key_pulldown_en(pd));
	hrc_key_model hrc_key_model_i (.pclk(pclk), .press(press),
		.ext_fire(ext_fire), .key_input_pins(keys), .ext_irq_pin(ext_pin));

	// =====
	// tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(pready), 32'h1);
	endtask : apb

	task cpu(input logic [3:0] v, input logic [3:0] o);
		@(posedge pclk);
		ins <= v;
		if (v[1])
			op <= o;
		@(posedge pclk);
		ins <= 4'h0;
	endtask : cpu

	// which: 0 resume, 1 ack, 2 ignored
	task wt(input int which, input int lim);
		int n;
		logic s;
		for (n = 0; n < lim; n++) begin
			#1;
			s = which == 0 ? resume : which == 1 ? ack : ignored;
			if (s === 1'b1)
				break;
			@(posedge pclk);
		end
		chk(32'(n < lim), 32'h1);
	endtask : wt

	task stop_test;
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	initial begin
		#400000;
		fails++;
		stop_test;
	end

	// =====
	// scenarios
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(hrc_pkg::OFF_CTRL, 1'b0, 32'h0);
		chk(rdat, 32'(hrc_pkg::CTRL_RST));
		apb(8'h10, 1'b0, 32'h0);
		chk({rdat[30:0], rerr}, 32'h1);
		chk(32'(pd), 32'hf);
		cpu(4'h2, 4'h1);
		press <= 4'h8;
		wt(0, 20);
		apb(hrc_pkg::OFF_FLAGS, 1'b0, 32'h0);
		chk(32'(rdat[1]), 32'h1);
		chk(32'(rdat[0]), 32'h1);
		press <= 4'h0;
		// operand zero: neither keys nor carries end the halt
		cpu(4'h2, 4'h0);
		press <= 4'hf;
		repeat (30) @(posedge pclk);
		chk(32'(halted), 32'h1);
		press <= 4'h0;
		presetn <= 1'b0;
		@(posedge pclk);
		#1 chk(32'(halted), 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		// release interval per select code, taken between two releases
		for (int s = 0; s < 4; s++) begin
			apb(hrc_pkg::OFF_CTRL, 1'b1, 32'(s));
			for (int k = 0; k < 3; k++) begin
				apb(hrc_pkg::OFF_FLAGS, 1'b1, 32'h1);
				cpu(4'h2, 4'h2);
				wt(0, 3000);
				if (k == 2)
					chk(32'(($time - t0) / 8), 32'(IV[s]) * CYC);
				t0 = $time;
			end
		end
		apb(hrc_pkg::OFF_FLAGS, 1'b0, 32'h0);
		chk(32'(rdat[0]), 32'h1);
		cpu(4'h2, 4'h2);
		wt(0, 4);
		// stale pending request refuses the halt, then priority order
		apb(hrc_pkg::OFF_IRQ, 1'b1, 32'h3);
		apb(hrc_pkg::OFF_CTRL, 1'b1, 32'h3f);
		cpu(4'h1, 4'h0);
		cpu(4'h4, 4'h0);
		cpu(4'h2, 4'h8);
		wt(2, 4);
		cpu(4'h1, 4'h0);
		wt(1, 4);
		chk(32'(vec), 32'(hrc_pkg::VEC_EXT));
		cpu(4'h4, 4'h0);
		cpu(4'h8, 4'h0);
		wt(1, 4);
		chk(32'(vec), 32'(hrc_pkg::VEC_TMR));
		cpu(4'h8, 4'h0);
		// a source without permission stays pending and keeps the halt
		apb(hrc_pkg::OFF_CTRL, 1'b1, 32'h0f);
		cpu(4'h4, 4'h0);
		cpu(4'h2, 4'h8);
		ext_fire <= 1'b1;
		@(posedge pclk);
		ext_fire <= 1'b0;
		repeat (20) @(posedge pclk);
		chk(32'(halted), 32'h1);
		apb(hrc_pkg::OFF_CTRL, 1'b1, 32'h1f);
		wt(0, 8);
		chk(32'(vec), 32'(hrc_pkg::VEC_EXT));
		stop_test;
	end
endmodule : hrc_top_tb
